//--- verilog/sbm_pkg.sv
// Purpose: shared constants and types for the system bus master port and its bus partner
// Assumes: one clock, sys_clk at 100 MHz; all bus lines active low on the wire
// Notes:   bus timing figures are held in ns and turned into cycle counts here
package sbm_pkg;
    localparam int ADDR_W          = 20;     // address lines, top line is the msb
    localparam int DATA_W          = 8;      // data lines, line 7 is the msb
    localparam int INT_W           = 8;      // interrupt lines, line 0 highest priority
    localparam int CLK_PERIOD_NS   = 10;     // sys_clk period
    localparam int ADDR_SETUP_R_NS = 286;    // address setup before read command
    localparam int ADDR_SETUP_W_NS = 786;    // address setup before write command
    localparam int ADDR_HOLD_NS    = 147;    // address hold after command
    localparam int ADDR_SETUP_R_CYC = (ADDR_SETUP_R_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_SETUP_W_CYC = (ADDR_SETUP_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_HOLD_CYC    = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 8;      // width of phase counters
    localparam logic [CNT_W-1:0] ACK_DELAY_DEF = 8'h03; // partner acknowledge latency

    // transfer kinds; encoded as {io, write}
    typedef enum logic [1:0] {
        SBM_MEM_RD = 2'h0,
        SBM_MEM_WR = 2'h1,
        SBM_IO_RD  = 2'h2,
        SBM_IO_WR  = 2'h3
    } sbm_kind_t;

    // master states, Gray coded along the usual path
    typedef enum logic [2:0] {
        SBM_IDLE  = 3'h0,
        SBM_ARB   = 3'h1,
        SBM_SETUP = 3'h3,
        SBM_CMD   = 3'h2,
        SBM_HOLD  = 3'h6
    } sbm_state_t;
endpackage : sbm_pkg

//--- verilog/sbm_bus_if.sv
// Purpose: the shared parallel system bus between the master port and its partner
// Assumes: every line is active low on the wire; drivers give output and enable
// Notes:   wire levels are resolved by the testbench from the enables
`timescale 1ns/1ps
interface sbm_bus_if;
    import sbm_pkg::*;
    logic              init_n;       // bus initialise, driven by partner
    logic              prio_in_n;    // priority in of the master
    logic              prio_out_n;   // priority out of the master
    logic              req_n;        // parallel bus request
    logic              busy_n_o;     // busy wire level
    logic              busy_oe_m;    // master pulls busy low
    logic              busy_oe_p;    // partner pulls busy low
    logic              cbrq_n_o;     // common request wire level
    logic              cbrq_oe_m;    // master pulls common request low
    logic [ADDR_W-1:0] addr_n;       // address lines
    logic              addr_oe;      // master drives address
    logic [DATA_W-1:0] data_n;       // resolved data wire level
    logic [DATA_W-1:0] data_m_n;     // master data drive
    logic              data_oe_m;    // master drives data
    logic [DATA_W-1:0] data_p_n;     // partner data drive
    logic              data_oe_p;    // partner drives data
    logic              mrd_n;        // memory read command
    logic              mwr_n;        // memory write command
    logic              iord_n;       // io read command
    logic              iowr_n;       // io write command
    logic              ack_n;        // transfer acknowledge
    logic [INT_W-1:0]  int_n;        // interrupt request lines
    logic [INT_W-1:0]  int_oe;       // master pulls interrupt lines low

    modport master (
        input  init_n, prio_in_n, busy_n_o, cbrq_n_o, data_n, ack_n,
        output prio_out_n, req_n, busy_oe_m, cbrq_oe_m, addr_n, addr_oe,
        output data_m_n, data_oe_m, mrd_n, mwr_n, iord_n, iowr_n, int_oe
    );
    modport partner (
        input  prio_out_n, req_n, busy_n_o, cbrq_n_o, addr_n, addr_oe, data_n,
        input  mrd_n, mwr_n, iord_n, iowr_n, int_n,
        output init_n, prio_in_n, busy_oe_p, data_p_n, data_oe_p, ack_n
    );
endinterface : sbm_bus_if

//--- verilog/sbm_master.sv
// Purpose: master end of the system bus: arbitration, commands, interrupt drive
// Assumes: bus inputs synchronous to sys_clk, which stands in for the bus clock
// Notes:   one transfer per user request; holds the bus while usr_more and usr_req are both high at the end of the hold
`timescale 1ns/1ps
module sbm_master
    import sbm_pkg::*;
#(
    parameter bit CBRQ_EN = 1'b1                         // use common bus request
) (
    input  wire logic              sys_clk,           // 100 MHz clock
    input  wire logic              rst_n,             // synchronous reset, active low
    sbm_bus_if.master              bus,               // system bus
    input  wire logic              usr_req,           // start a transfer (level, taken when usr_ready)
    input  wire sbm_kind_t         usr_kind,          // transfer kind
    input  wire logic [ADDR_W-1:0] usr_addr,          // transfer address
    input  wire logic [DATA_W-1:0] usr_wdata,         // write data
    input  wire logic              usr_more,          // keep the bus for another transfer
    input  wire logic [INT_W-1:0]  usr_int,           // interrupt requests to raise
    output logic                   usr_ready,         // ready to take a request
    output logic                   usr_done,          // one-cycle pulse at transfer end
    output logic [DATA_W-1:0]      usr_rdata,         // read data, valid with usr_done
    output logic                   usr_owner          // bus is owned
);
    sbm_state_t        st_q, st_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    sbm_kind_t         kind_q, kind_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic              want_q, want_d, own_q, own_d, cmd_q, cmd_d;
    logic              done_q, done_d, rdy_q, rdy_d, prio_q, prio_d;
    logic              req_q, req_d, cbrq_q, cbrq_d;
    logic [INT_W-1:0]  int_q, int_d;
    logic [3:0]        strb_n_q, strb_n_d;                // command strobes {mrd, mwr, iord, iowr}, active low
    logic              reset_all;

    // setup time before a command for the given kind
    function automatic logic [CNT_W-1:0] setup_cyc(input sbm_kind_t k);
        setup_cyc = k[0] ? CNT_W'(ADDR_SETUP_W_CYC) : CNT_W'(ADDR_SETUP_R_CYC);
    endfunction : setup_cyc

    // active-low one-hot strobe for a kind, ordered {mem rd, mem wr, io rd, io wr}
    function automatic logic [3:0] strobe_n(input sbm_kind_t k);
        strobe_n = ~(4'h8 >> k);
    endfunction : strobe_n

    assign reset_all = !rst_n || !bus.init_n;

    // next-state logic for arbitration and command sequencing
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        kind_d = kind_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        want_d = want_q;
        own_d  = own_q;
        cmd_d  = cmd_q;
        done_d = 1'b0;
        rdy_d  = 1'b0;
        int_d  = usr_int;
        case (st_q)
            SBM_IDLE: begin
                rdy_d = !own_q;
                if (usr_req && rdy_q) begin
                    kind_d = usr_kind;
                    addr_d = usr_addr;
                    wdat_d = usr_wdata;
                    want_d = 1'b1;
                    rdy_d  = 1'b0;
                    st_d   = SBM_ARB;
                end
            end
            SBM_ARB: begin
                // bus taken only with priority in and a free busy line
                if (!bus.prio_in_n && bus.busy_n_o) begin
                    own_d = 1'b1;
                    cnt_d = setup_cyc(kind_q);
                    st_d  = SBM_SETUP;
                end
            end
            SBM_SETUP: begin
                if (cnt_q > 1) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    cmd_d = 1'b1;
                    st_d  = SBM_CMD;
                end
            end
            SBM_CMD: begin
                if (!bus.ack_n) begin
                    if (!kind_q[0]) begin
                        rdat_d = ~bus.data_n;
                    end
                    cmd_d  = 1'b0;
                    cnt_d  = CNT_W'(ADDR_HOLD_CYC);
                    done_d = 1'b1;
                    st_d   = SBM_HOLD;
                end
            end
            SBM_HOLD: begin
                if (cnt_q > 1) begin
                    cnt_d = cnt_q - 1'b1;
                end else if (usr_more && usr_req) begin
                    kind_d = usr_kind;                    // next transfer keeps busy held
                    addr_d = usr_addr;
                    wdat_d = usr_wdata;
                    cnt_d  = setup_cyc(usr_kind);
                    st_d   = SBM_SETUP;
                end else begin
                    own_d  = 1'b0;
                    want_d = 1'b0;
                    st_d   = SBM_IDLE;
                end
            end
            default: begin
                st_d = SBM_IDLE;
            end
        endcase
        // priority out blocks lower masters while wanting, passes it otherwise
        prio_d = want_d;
        req_d  = want_d;
        cbrq_d = CBRQ_EN && want_d && !own_d;
        // strobes decoded ahead of the flop so the command pins cannot glitch
        strb_n_d = cmd_d ? strobe_n(kind_d) : 4'hF;
    end

    // state registers, cleared by reset or bus initialise
    always_ff @(posedge sys_clk) begin
        if (reset_all) begin
            st_q   <= SBM_IDLE;
            cnt_q  <= '0;
            kind_q <= SBM_MEM_RD;
            addr_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            want_q <= 1'b0;
            own_q  <= 1'b0;
            cmd_q  <= 1'b0;
            done_q <= 1'b0;
            rdy_q  <= 1'b0;
            prio_q <= 1'b0;
            req_q  <= 1'b0;
            cbrq_q <= 1'b0;
            int_q  <= '0;
            strb_n_q <= 4'hF;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            want_q <= want_d;
            own_q  <= own_d;
            cmd_q  <= cmd_d;
            done_q <= done_d;
            rdy_q  <= rdy_d;
            prio_q <= prio_d;
            req_q  <= req_d;
            cbrq_q <= cbrq_d;
            int_q  <= int_d;
            strb_n_q <= strb_n_d;
        end
    end

    // bus drive: request, address and data inverted; strobes and priority out already at wire level, active low on the wire
    assign bus.prio_out_n = prio_q;
    assign bus.req_n      = !req_q;
    assign bus.busy_oe_m  = own_q;
    assign bus.cbrq_oe_m  = cbrq_q;
    assign bus.addr_n     = ~addr_q;
    assign bus.addr_oe    = own_q;
    assign bus.data_m_n   = ~wdat_q;
    assign bus.data_oe_m  = own_q && kind_q[0];
    assign bus.mrd_n      = strb_n_q[3];
    assign bus.mwr_n      = strb_n_q[2];
    assign bus.iord_n     = strb_n_q[1];
    assign bus.iowr_n     = strb_n_q[0];
    assign bus.int_oe     = int_q;

    assign usr_ready = rdy_q;
    assign usr_done  = done_q;
    assign usr_rdata = rdat_q;
    assign usr_owner = own_q;
endmodule : sbm_master

//--- verilog/sbm_partner.sv
// Purpose: partner end of the system bus: memory and io responder, init and priority source
// Assumes: commands from the master are synchronous to sys_clk
// Notes:   a small memory and port file answer every command after a fixed latency
`timescale 1ns/1ps
module sbm_partner
    import sbm_pkg::*;
#(
    parameter int               MEM_AW  = 8,             // memory address bits kept
    parameter logic [CNT_W-1:0] ACK_DLY = ACK_DELAY_DEF  // cycles from command to acknowledge
) (
    input  wire logic              sys_clk,           // 100 MHz clock
    input  wire logic              rst_n,             // synchronous reset, active low
    sbm_bus_if.partner             bus,               // system bus
    input  wire logic              usr_init,          // request bus initialise
    input  wire logic              usr_prio,          // grant priority to the master
    input  wire logic              usr_hold_busy,     // another master holds busy
    output logic [INT_W-1:0]       usr_irq,           // interrupt lines seen, active high
    output logic                   usr_lower_prio     // priority passed downstream
);
    logic [DATA_W-1:0] mem_q [2**MEM_AW];
    logic [DATA_W-1:0] port_q [2**MEM_AW];
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic              ack_q, ack_d, drv_q, drv_d;
    logic [DATA_W-1:0] rd_q, rd_d;
    logic              init_q, prio_q, busy_q, lp_q;
    logic [INT_W-1:0]  irq_q;
    logic              cmd_any, is_rd, is_wr, is_io;
    logic [MEM_AW-1:0] a;

    assign is_rd   = !bus.mrd_n || !bus.iord_n;
    assign is_wr   = !bus.mwr_n || !bus.iowr_n;
    assign is_io   = !bus.iord_n || !bus.iowr_n;
    assign cmd_any = is_rd || is_wr;
    assign a       = ~bus.addr_n[MEM_AW-1:0];

    // acknowledge timing; ack held until the command goes away
    always_comb begin
        cnt_d = cnt_q;
        ack_d = ack_q;
        drv_d = drv_q;
        rd_d  = rd_q;
        if (!cmd_any) begin
            cnt_d = '0;
            ack_d = 1'b0;
            drv_d = 1'b0;
        end else if (!ack_q) begin
            if (cnt_q + 1'b1 >= ACK_DLY) begin
                ack_d = 1'b1;
                drv_d = is_rd;
                rd_d  = is_io ? port_q[a] : mem_q[a];
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // registers for acknowledge, read data and sampled controls; write storage is in the block below
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            ack_q  <= 1'b0;
            drv_q  <= 1'b0;
            rd_q   <= '0;
            init_q <= 1'b0;
            prio_q <= 1'b0;
            busy_q <= 1'b0;
            lp_q   <= 1'b0;
            irq_q  <= '0;
        end else begin
            cnt_q  <= cnt_d;
            ack_q  <= ack_d;
            drv_q  <= drv_d;
            rd_q   <= rd_d;
            init_q <= usr_init;
            prio_q <= usr_prio;
            busy_q <= usr_hold_busy;
            lp_q   <= !bus.prio_out_n;
            irq_q  <= ~bus.int_n;
        end
    end

    // write data taken as the acknowledge is raised
    always_ff @(posedge sys_clk) begin
        if (ack_d && !ack_q && is_wr) begin
            if (is_io) begin
                port_q[a] <= ~bus.data_n;
            end else begin
                mem_q[a] <= ~bus.data_n;
            end
        end
    end

    assign bus.init_n    = !init_q;
    assign bus.prio_in_n = !prio_q;
    assign bus.busy_oe_p = busy_q;
    assign bus.ack_n     = !ack_q;
    assign bus.data_p_n  = ~rd_q;
    assign bus.data_oe_p = drv_q;
    assign usr_irq        = irq_q;
    assign usr_lower_prio = lp_q;
endmodule : sbm_partner

//--- tb/sbm_checker.sv
// Purpose: protocol checks on the shared system bus between both ends
// Assumes: every line is sampled on sys_clk and is active low on the wire
// Notes:   takes plain copies of the interface signals
`timescale 1ns/1ps
module sbm_checker
    import sbm_pkg::*;
(
    input wire logic sys_clk,    // bus clock
    input wire logic rst_n,      // sync reset, active low
    input wire logic init_n,     // bus initialise
    input wire logic prio_in_n,  // priority in
    input wire logic prio_out_n, // priority out
    input wire logic req_n,      // bus request
    input wire logic busy_n_o,   // busy wire level
    input wire logic busy_oe_m,  // master holds busy
    input wire logic cbrq_oe_m,  // master common request
    input wire logic addr_oe,    // address driven
    input wire logic data_oe_m,  // master drives data
    input wire logic data_oe_p,  // partner drives data
    input wire logic mrd_n,      // memory read command
    input wire logic mwr_n,      // memory write command
    input wire logic iord_n,     // io read command
    input wire logic iowr_n,     // io write command
    input wire logic ack_n       // transfer acknowledge
);
    logic       cmd_on;  // some command is low
    logic [7:0] setup_q; // address cycles ahead of a command
    logic [7:0] setup_d;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // any command on the wire
    assign cmd_on = !(mrd_n && mwr_n && iord_n && iowr_n);

    // counts address-valid cycles before a command, saturating
    always_comb begin
        setup_d = setup_q;
        if (!addr_oe || cmd_on) setup_d = 8'h00;
        else if (setup_q != 8'hFF) setup_d = setup_q + 8'h01;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) setup_q <= 8'h00;
        else setup_q <= setup_d;
    end

    // a command that ends outside an initialise
    sequence s_cmd_end;
        $rose(!cmd_on) && $past(init_n);
    endsequence
    sequence s_cmd_start;
        $rose(cmd_on);
    endsequence

    cmd_onehot_a: assert property ($onehot0({!mrd_n, !mwr_n, !iord_n, !iowr_n}))
        else $error("more than one command low");
    owner_cmd_a: assert property (cmd_on |-> busy_oe_m && addr_oe)
        else $error("command without busy or address");
    take_free_a: assert property ($rose(busy_oe_m) |-> !$past(prio_in_n) && $past(busy_n_o))
        else $error("bus taken without priority or while busy");
    want_block_a: assert property (!req_n |-> prio_out_n)
        else $error("priority passed on while requesting");
    cbrq_owner_a: assert property (busy_oe_m |-> !cbrq_oe_m)
        else $error("common request held while owner");
    cmd_after_ack_a: assert property (s_cmd_end |-> !$past(ack_n))
        else $error("command ended without acknowledge");
    ack_bound_a: assert property (s_cmd_start |-> ##[1:12] !ack_n)
        else $error("no acknowledge to command");
    rd_drive_a: assert property ((!mrd_n || !iord_n) && !ack_n |-> data_oe_p && !data_oe_m)
        else $error("read data not driven by responder");
    wr_drive_a: assert property (!mwr_n || !iowr_n |-> data_oe_m && !data_oe_p)
        else $error("write data not driven by master");
    setup_rd_a: assert property ($fell(mrd_n) || $fell(iord_n) |-> setup_q >= ADDR_SETUP_R_CYC - 1)
        else $error("read address setup too short");
    setup_wr_a: assert property ($fell(mwr_n) || $fell(iowr_n) |-> setup_q >= ADDR_SETUP_W_CYC - 1)
        else $error("write address setup too short");
endmodule : sbm_checker

//--- tb/system_bus_master_port_tb.sv
// Purpose: drives both ends of the system bus and judges transfers
// Assumes: partner answers after its default acknowledge delay
// Notes:   shared wire levels are resolved here from the drivers' enables; address and command lines are taken as driven
`timescale 1ns/1ps
module system_bus_master_port_tb;
    import sbm_pkg::*;
    logic              sys_clk, rst_n, usr_req, usr_more, usr_init, usr_prio, usr_hold_busy;
    logic              usr_ready, usr_done, usr_owner, usr_lower_prio;
    sbm_kind_t         usr_kind;
    logic [ADDR_W-1:0] usr_addr;
    logic [DATA_W-1:0] usr_wdata, usr_rdata, rd;
    logic [INT_W-1:0]  usr_int, usr_irq;
    int                bad_count, samples_checked;

    sbm_bus_if bus ();

    // open-collector and shared lines, data pulled up when released
    assign bus.busy_n_o = ~(bus.busy_oe_m | bus.busy_oe_p);
    assign bus.cbrq_n_o = ~bus.cbrq_oe_m;
    assign bus.int_n    = ~bus.int_oe;
    assign bus.data_n   = bus.data_oe_m ? bus.data_m_n : (bus.data_oe_p ? bus.data_p_n : 8'hFF);

    sbm_master #(.CBRQ_EN(1'b1)) sbm_master_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.master),
        .usr_req(usr_req), .usr_kind(usr_kind), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
        .usr_more(usr_more), .usr_int(usr_int), .usr_ready(usr_ready), .usr_done(usr_done),
        .usr_rdata(usr_rdata), .usr_owner(usr_owner));
    sbm_partner #(.MEM_AW(8), .ACK_DLY(ACK_DELAY_DEF)) sbm_partner_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .bus(bus.partner), .usr_init(usr_init), .usr_prio(usr_prio), .usr_hold_busy(usr_hold_busy),
        .usr_irq(usr_irq), .usr_lower_prio(usr_lower_prio));
    sbm_checker sbm_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n), .init_n(bus.init_n),
        .prio_in_n(bus.prio_in_n), .prio_out_n(bus.prio_out_n), .req_n(bus.req_n), .busy_n_o(bus.busy_n_o),
        .busy_oe_m(bus.busy_oe_m), .cbrq_oe_m(bus.cbrq_oe_m), .addr_oe(bus.addr_oe), .data_oe_m(bus.data_oe_m),
        .data_oe_p(bus.data_oe_p), .mrd_n(bus.mrd_n), .mwr_n(bus.mwr_n), .iord_n(bus.iord_n),
        .iowr_n(bus.iowr_n), .ack_n(bus.ack_n));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    // a used-up wait counts as a mismatch and closes the run
    task automatic tmo();
        chk(32'h0, 32'h1);
        end_sim();
    endtask : tmo

    // presents one request and holds it until taken; a held bus takes it at the end of its hold
    task automatic issue(input sbm_kind_t k, input logic [19:0] a, input logic [7:0] wd, input logic more);
        int n;
        n = 0;
        usr_kind = k;
        usr_addr = a;
        usr_wdata = wd;
        usr_more = more;
        usr_req = 1'b1;
        if (more && usr_owner === 1'b1) begin
            // no ready on this path: the new command on the wire shows it was taken
            while (bus.mrd_n & bus.mwr_n & bus.iord_n & bus.iowr_n) begin
                @(negedge sys_clk);
                n++;
                if (n > 300) tmo();
            end
        end else begin
            while (usr_ready !== 1'b1) begin
                @(negedge sys_clk);
                n++;
                if (n > 300) tmo();
            end
            @(negedge sys_clk);
        end
        usr_req = 1'b0;
    endtask : issue

    // watches the command on the wire, then waits for completion
    task automatic finish(input sbm_kind_t k, input logic [19:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        while (bus.mrd_n & bus.mwr_n & bus.iord_n & bus.iowr_n) begin
            @(negedge sys_clk);
            n++;
            if (n > 400) tmo();
        end
        chk(bus.addr_n, 20'(~a));
        if (k[0]) chk(bus.data_n, 8'(~wd));
        chk({bus.mrd_n, bus.mwr_n, bus.iord_n, bus.iowr_n}, 4'(~(4'h8 >> k)));
        n = 0;
        while (usr_done !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 300) tmo();
        end
        rd = usr_rdata;
    endtask : finish

    task automatic xfer(input sbm_kind_t k, input logic [19:0] a, input logic [7:0] wd, input logic more);
        issue(k, a, wd, more);
        finish(k, a, wd);
    endtask : xfer

    // memory and io are separate spaces at the same address
    task automatic t_kinds();
        xfer(SBM_MEM_WR, 20'h80012, 8'hA5, 1'b0);
        xfer(SBM_IO_WR, 20'h80012, 8'h3C, 1'b0);
        xfer(SBM_MEM_RD, 20'h80012, 8'h00, 1'b0);
        chk(rd, 8'hA5);
        xfer(SBM_IO_RD, 20'h80012, 8'h00, 1'b0);
        chk(rd, 8'h3C);
    endtask : t_kinds

    // request held off by missing priority or by another owner's busy
    task automatic t_blocked(input logic by_busy);
        usr_prio = by_busy;
        usr_hold_busy = by_busy;
        issue(SBM_MEM_WR, 20'h00040, 8'h81, 1'b0);
        repeat (40) @(negedge sys_clk);
        chk({bus.prio_out_n, bus.req_n, bus.cbrq_n_o, bus.busy_oe_m, bus.mwr_n}, 5'h11);
        chk(usr_lower_prio, 1'b0);
        usr_prio = 1'b1;
        usr_hold_busy = 1'b0;
        finish(SBM_MEM_WR, 20'h00040, 8'h81);
        chk(bus.cbrq_n_o, 1'b1);
    endtask : t_blocked

    // two transfers under one ownership, then release
    task automatic t_burst();
        xfer(SBM_MEM_WR, 20'h00077, 8'h5A, 1'b1);
        chk({bus.busy_oe_m, usr_owner}, 2'h3);
        xfer(SBM_MEM_RD, 20'h00077, 8'h00, 1'b1);
        chk(rd, 8'h5A);
        usr_more = 1'b0;
        repeat (40) @(negedge sys_clk);
        chk({bus.busy_oe_m, bus.prio_out_n, usr_lower_prio, usr_owner}, 4'h2);
    endtask : t_burst

    // each interrupt line alone
    task automatic t_int();
        for (int i = 0; i < INT_W; i++) begin
            usr_int = 8'h01 << i;
            repeat (3) @(negedge sys_clk);
            chk(bus.int_n, 8'(~(8'h01 << i)));
            chk(usr_irq, 8'h01 << i);
        end
        usr_int = 8'h00;
    endtask : t_int

    // initialise while arbitrating drops the request
    task automatic t_init();
        usr_prio = 1'b0;
        issue(SBM_IO_WR, 20'h00005, 8'h66, 1'b0);
        repeat (5) @(negedge sys_clk);
        usr_init = 1'b1;
        repeat (2) @(negedge sys_clk);
        usr_init = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({bus.req_n, bus.prio_out_n, bus.cbrq_n_o, usr_ready}, 4'hB);
        usr_prio = 1'b1;
    endtask : t_init

    // main sequence
    initial begin
        bad_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        usr_req = 1'b0;
        usr_more = 1'b0;
        usr_init = 1'b0;
        usr_prio = 1'b1;
        usr_hold_busy = 1'b0;
        usr_kind = SBM_MEM_RD;
        usr_addr = 20'h00000;
        usr_wdata = 8'h00;
        usr_int = 8'h00;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk({bus.mrd_n, bus.mwr_n, bus.iord_n, bus.iowr_n, bus.req_n, bus.prio_out_n, bus.busy_oe_m, bus.cbrq_oe_m},
            8'hF8);
        t_kinds();
        t_blocked(1'b0);
        t_blocked(1'b1);
        t_burst();
        t_int();
        t_init();
        end_sim();
    end
endmodule : system_bus_master_port_tb
